// ===== include/isa_slot_pkg.sv
// Purpose: shared constants for the expansion slot host and card ends
// Assumes: one 250 MHz clock, bus clock derived by division
// Notes: How it works list below
// How it works
// - address enable detaches processor during DMA
// - latch system address on latch-enable fall
// - latch enable held high through DMA
// - bus clock driven at half duty
// - not-ready stretches cycle by whole clocks
// - card holds not-ready at most 2.5 us
// - upper byte steered to low lanes
// - 16-bit access to 8-bit split twice
// - one active-low acknowledge per DMA channel
// - DMA channel 0 highest, 7 lowest
// - requests held until acknowledged, synchronised
// - channels 0-3 byte, 5-7 word
// - I/O 16 select gives word, one wait
// - channel check flags uncorrectable error
// - I/O strobes active low, any master
// - interrupt 9 highest, 7 lowest
// - interrupts on rising edge, held high
// - upper address valid while latch high
// - memory 16 select gives word, one wait
// - master select tri-states host drivers
// - master waits one then two clocks
// - master releases select within 15 us
package isa_slot_pkg;
  localparam int BCLK_HALF_DIV = 16;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int READY_MAX_NS = 2500;
  localparam int READY_MAX_CYC = (READY_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int MASTER_MAX_NS = 15000;
  localparam int MASTER_MAX_CYC = (MASTER_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int BASE_WAITS = 4;
  localparam int WIDE_WAITS = 1;
  localparam int DMA_CHANNELS = 8;
  localparam int IRQ_LINES = 16;
  localparam int CASCADE_CH = 4;
  localparam logic [7:0] BYTE_CH_MASK = 8'h0f;
  localparam logic [15:0] IRQ_USED_MASK = 16'hdef8;
  localparam logic [3:0] IRQ_NONE = 4'h0;
endpackage

// ===== include/isa_slot_if.sv
// Purpose: slot wires between host and card ends
// Assumes: enables high while a party drives
// Notes: shared lines resolved from enables here
`timescale 1ns/1ps
`default_nettype none
interface isa_slot_if;
  logic bclk;
  logic resdrv;
  logic aen;
  logic bale;
  logic tc;
  logic [7:0] dak_n;
  logic [7:0] drq;
  logic [15:0] irq;
  logic chrdy_n_o;
  logic io16_n;
  logic m16_n;
  logic chk_n;
  logic master_n;
  logic [23:0] h_addr;
  logic h_addr_oe;
  logic [23:0] c_addr;
  logic c_addr_oe;
  logic [15:0] h_data;
  logic h_data_oe;
  logic [15:0] c_data;
  logic c_data_oe;
  logic h_ior_n;
  logic h_iow_n;
  logic h_cmd_oe;
  logic h_sbhe_n;
  logic c_ior_n;
  logic c_iow_n;
  logic c_cmd_oe;
  logic [23:0] addr;
  logic [15:0] data;
  logic ior_n;
  logic iow_n;
  assign addr = h_addr_oe ? h_addr : (c_addr_oe ? c_addr : 24'h00_0000);
  assign data = h_data_oe ? h_data : (c_data_oe ? c_data : 16'hffff);
  assign ior_n = (h_cmd_oe ? h_ior_n : 1'b1) & (c_cmd_oe ? c_ior_n : 1'b1);
  assign iow_n = (h_cmd_oe ? h_iow_n : 1'b1) & (c_cmd_oe ? c_iow_n : 1'b1);
  modport host (
    output bclk, resdrv, aen, bale, tc, dak_n, h_addr, h_addr_oe, h_data, h_data_oe,
    output h_ior_n, h_iow_n, h_cmd_oe, h_sbhe_n,
    input drq, irq, chrdy_n_o, io16_n, m16_n, chk_n, master_n, addr, data, ior_n, iow_n
  );
  modport card (
    input bclk, resdrv, aen, bale, tc, dak_n, addr, data, ior_n, iow_n, h_sbhe_n,
    output drq, irq, chrdy_n_o, io16_n, m16_n, chk_n, master_n,
    output c_addr, c_addr_oe, c_data, c_data_oe, c_ior_n, c_iow_n, c_cmd_oe
  );
endinterface
`default_nettype wire

// ===== src/isa_slot_card.sv
// Purpose: adapter end: I/O register target, DMA and master requester
// Assumes: clocked by system clock, samples bus clock as a level
// Notes: register at reg_addr; in byte mode high half at the next address
`timescale 1ns/1ps
`default_nettype none
module isa_slot_card #(
  parameter logic [15:0] REG_ADDR = 16'h0300,
  parameter int WAIT_CLKS = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  isa_slot_if.card slot,
  input wire logic wide,
  input wire logic [7:0] dma_req,
  input wire logic [15:0] irq_in,
  input wire logic err,
  input wire logic take_bus,
  output logic [15:0] reg_value,
  output logic dma_granted,
  output logic owns_bus
);
  logic [1:0] bclk_sync_reg;
  logic bclk_q_reg;
  logic [15:0] reg_reg, reg_next;
  logic [3:0] wait_reg, wait_next;
  logic [7:0] drq_reg, drq_next;
  logic [2:0] own_reg, own_next;
  logic [1:0] ior_sync_reg, iow_sync_reg;
  logic iow_q_reg;
  logic hit;
  logic hit_lo;
  logic hit_hi;
  logic rise;
  // bus clock and strobe synchronisers
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      bclk_sync_reg <= 2'b00;
      bclk_q_reg <= 1'b0;
      ior_sync_reg <= 2'b11;
      iow_sync_reg <= 2'b11;
      iow_q_reg <= 1'b1;
    end
    else if (ce)
    begin
      bclk_sync_reg <= {bclk_sync_reg[0], slot.bclk};
      bclk_q_reg <= bclk_sync_reg[1];
      ior_sync_reg <= {ior_sync_reg[0], slot.ior_n};
      iow_sync_reg <= {iow_sync_reg[0], slot.iow_n};
      iow_q_reg <= iow_sync_reg[1];
    end
  assign rise = bclk_sync_reg[1] & ~bclk_q_reg;
  // byte-wide card answers two addresses, one per register half
  assign hit_lo = ~slot.aen && slot.addr[15:0] == REG_ADDR;
  assign hit_hi = ~slot.aen && ~wide && slot.addr[15:0] == REG_ADDR + 16'h0001;
  assign hit = hit_lo | hit_hi;
  // register, wait count, requests, master takeover
  always_comb
  begin
    reg_next = reg_reg;
    wait_next = wait_reg;
    drq_next = (drq_reg | dma_req) & slot.dak_n;
    own_next = own_reg;
    if (hit && iow_sync_reg[1] && !iow_q_reg)
    begin
      if (wide)
        reg_next = slot.data;
      else if (hit_hi)
        reg_next[15:8] = slot.data[7:0];
      else
        reg_next[7:0] = slot.data[7:0];
    end
    if (hit && (!ior_sync_reg[1] || !iow_sync_reg[1]))
    begin
      if (wait_reg != 4'(WAIT_CLKS) && rise)
        wait_next = wait_reg + 4'h1;
    end
    else
      wait_next = 4'h0;
    // takeover steps: select low, then address after a whole bus clock, commands after two
    if (!take_bus)
      own_next = 3'h0;
    else if (!slot.dak_n[isa_slot_pkg::CASCADE_CH] && own_reg == 3'h0)
      own_next = 3'h1;
    else if (own_reg != 3'h0 && own_reg != 3'h4 && rise)
      own_next = own_reg + 3'h1;
    reg_next = slot.resdrv ? 16'h0000 : reg_next;
  end
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      reg_reg <= 16'h0000;
      wait_reg <= 4'h0;
      drq_reg <= 8'h00;
      own_reg <= 3'h0;
    end
    else if (ce)
    begin
      reg_reg <= reg_next;
      wait_reg <= wait_next;
      drq_reg <= drq_next;
      own_reg <= own_next;
    end
  // slot drive
  assign slot.drq = drq_reg | (take_bus ? 8'h10 : 8'h00);
  assign slot.irq = irq_in;
  assign slot.chrdy_n_o = hit && (!ior_sync_reg[1] || !iow_sync_reg[1]) && wait_reg != 4'(WAIT_CLKS);
  assign slot.io16_n = ~(hit & wide);
  assign slot.m16_n = 1'b1;
  assign slot.chk_n = ~err;
  assign slot.master_n = ~(own_reg != 3'h0);
  assign slot.c_addr = {8'h00, REG_ADDR};
  assign slot.c_addr_oe = own_reg >= 3'h3;
  assign slot.c_data = hit_hi ? {8'h00, reg_reg[15:8]} : reg_reg;
  assign slot.c_data_oe = hit & ~slot.ior_n;
  assign slot.c_ior_n = 1'b1;
  assign slot.c_iow_n = 1'b1;
  assign slot.c_cmd_oe = own_reg == 3'h4;
  assign reg_value = reg_reg;
  assign dma_granted = ~&slot.dak_n;
  assign owns_bus = own_reg != 3'h0;
endmodule
`default_nettype wire

// ===== src/isa_slot_host.sv
// Purpose: host end of slot: bus clock, I/O cycles, DMA and interrupt arbitration
// Assumes: one clock, slot inputs asynchronous
// Notes: word access to byte target split in two
`timescale 1ns/1ps
`default_nettype none
module isa_slot_host #(
  parameter int HALF_DIV = isa_slot_pkg::BCLK_HALF_DIV
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  isa_slot_if.host slot,
  input wire logic sys_reset,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [23:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic done,
  output logic [15:0] rdata,
  input wire logic tc_in,
  output logic [2:0] dma_chan,
  output logic dma_active,
  output logic dma_word,
  output logic [3:0] irq_num,
  output logic irq_pending,
  input wire logic irq_ack,
  output logic chan_error,
  output logic master_active
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_CMD = 5'b00100,
    S_END = 5'b01000,
    S_DMA = 5'b10000
  } state_t;
  state_t state_reg, state_next;
  logic [7:0] div_reg, div_next;
  logic bclk_reg, bclk_next;
  logic [3:0] cnt_reg, cnt_next;
  logic hi_reg, hi_next;
  logic split_reg, split_next;
  logic write_reg, write_next;
  logic word_reg, word_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] rdata_reg, rdata_next;
  logic done_reg, done_next;
  logic [2:0] chan_reg, chan_next;
  logic [15:0] irq_q_reg, irq_pend_reg, irq_pend_next;
  logic err_reg, err_next;
  logic [1:0] s_rdy, s_io16, s_m16, s_chk, s_mst;
  logic [7:0] s_drq0, s_drq1;
  logic [15:0] s_irq0, s_irq1;
  logic edge_b;
  logic [7:0] drq_ok;
  logic [4:0] dma_pick;
  logic [4:0] irq_pick;
  // lowest-index set bit of a vector, or in interrupt order 9-15 then 3-7, with found flag
  function automatic logic [4:0] pick(input logic [15:0] v, input logic irq_order);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 15; i >= 0; i--)
      if (v[i] && !irq_order)
        r = {1'b1, 4'(i)};
    if (irq_order)
    begin
      for (int i = 7; i >= 3; i--)
        if (v[i])
          r = {1'b1, 4'(i)};
      for (int i = 15; i >= 9; i--)
        if (v[i])
          r = {1'b1, 4'(i)};
    end
    return r;
  endfunction
  // two-flop synchronisers for ready, size, check, master, request and interrupt inputs
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      s_rdy <= 2'b00;
      s_io16 <= 2'b11;
      s_m16 <= 2'b11;
      s_chk <= 2'b11;
      s_mst <= 2'b11;
      s_drq0 <= 8'h00;
      s_drq1 <= 8'h00;
      s_irq0 <= 16'h0000;
      s_irq1 <= 16'h0000;
      irq_q_reg <= 16'h0000;
    end
    else if (ce)
    begin
      s_rdy <= {s_rdy[0], ~slot.chrdy_n_o};
      s_io16 <= {s_io16[0], slot.io16_n};
      s_m16 <= {s_m16[0], slot.m16_n};
      s_chk <= {s_chk[0], slot.chk_n};
      s_mst <= {s_mst[0], slot.master_n};
      s_drq0 <= slot.drq;
      s_drq1 <= s_drq0;
      s_irq0 <= slot.irq;
      s_irq1 <= s_irq0;
      irq_q_reg <= s_irq1;
    end
  assign drq_ok = s_drq1 & 8'hef;
  // winning DMA channel and interrupt line, each with found flag
  assign dma_pick = pick({8'h00, drq_ok}, 1'b0);
  assign irq_pick = pick(irq_pend_reg, 1'b1);
  // next-state logic for bus clock, cycles, DMA and interrupts
  always_comb
  begin
    div_next = div_reg + 8'h01;
    bclk_next = bclk_reg;
    if (div_reg == 8'(HALF_DIV - 1))
    begin
      div_next = 8'h00;
      bclk_next = ~bclk_reg;
    end
    state_next = state_reg;
    cnt_next = cnt_reg;
    hi_next = hi_reg;
    split_next = split_reg;
    write_next = write_reg;
    word_next = word_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    rdata_next = rdata_reg;
    done_next = 1'b0;
    chan_next = chan_reg;
    unique case (state_reg)
      S_IDLE:
        if (s_drq1[isa_slot_pkg::CASCADE_CH] && !s_mst[1])
          state_next = S_IDLE;
        else if (dma_pick[4] && edge_b)
        begin
          chan_next = dma_pick[2:0];
          state_next = S_DMA;
        end
        else if (req_valid && edge_b && s_mst[1])
        begin
          write_next = req_write;
          word_next = req_word;
          addr_next = req_addr;
          wdata_next = req_wdata;
          hi_next = 1'b0;
          split_next = 1'b0;
          state_next = S_ADDR;
        end
      S_ADDR:
        if (edge_b)
        begin
          cnt_next = 4'h0;
          state_next = S_CMD;
        end
      S_CMD:
        if (edge_b)
        begin
          if (cnt_reg == 4'h0 && word_reg && !hi_reg)
            split_next = s_io16[1] & s_m16[1];
          if (cnt_reg < 4'(split_next ? isa_slot_pkg::BASE_WAITS : isa_slot_pkg::WIDE_WAITS))
            cnt_next = cnt_reg + 4'h1;
          else if (s_rdy[1])
          begin
            if (!write_reg)
            begin
              if (hi_reg)
                rdata_next[15:8] = slot.data[7:0];
              else if (split_next || !word_reg)
                rdata_next[7:0] = slot.data[7:0];
              else
                rdata_next = slot.data;
            end
            state_next = S_END;
          end
        end
      S_END:
        if (edge_b)
        begin
          if (split_reg && !hi_reg)
          begin
            hi_next = 1'b1;
            addr_next = addr_reg + 24'h00_0001;
            state_next = S_ADDR;
          end
          else
          begin
            done_next = 1'b1;
            state_next = S_IDLE;
          end
        end
      S_DMA:
        if (!s_drq1[chan_reg] && edge_b)
          state_next = S_IDLE;
      default:
        state_next = S_IDLE;
    endcase
    irq_pend_next = (irq_pend_reg & ~((irq_ack ? 16'h0001 : 16'h0000) << irq_num))
      | (s_irq1 & ~irq_q_reg & isa_slot_pkg::IRQ_USED_MASK);
    err_next = err_reg | ~s_chk[1];
  end
  assign edge_b = (div_reg == 8'(HALF_DIV - 1)) & ~bclk_reg & ce;
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      state_reg <= S_IDLE;
      div_reg <= 8'h00;
      bclk_reg <= 1'b0;
      cnt_reg <= 4'h0;
      hi_reg <= 1'b0;
      split_reg <= 1'b0;
      write_reg <= 1'b0;
      word_reg <= 1'b0;
      addr_reg <= 24'h00_0000;
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      done_reg <= 1'b0;
      chan_reg <= 3'h0;
      irq_pend_reg <= 16'h0000;
      err_reg <= 1'b0;
    end
    else if (ce)
    begin
      state_reg <= state_next;
      div_reg <= div_next;
      bclk_reg <= bclk_next;
      cnt_reg <= cnt_next;
      hi_reg <= hi_next;
      split_reg <= split_next;
      write_reg <= write_next;
      word_reg <= word_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      rdata_reg <= rdata_next;
      done_reg <= done_next;
      chan_reg <= chan_next;
      irq_pend_reg <= irq_pend_next;
      err_reg <= err_next;
    end
  // slot drive
  assign master_active = ~s_mst[1];
  assign slot.bclk = bclk_reg;
  assign slot.resdrv = sys_reset;
  assign slot.aen = state_reg == S_DMA;
  assign slot.bale = state_reg == S_ADDR || state_reg == S_DMA;
  assign slot.tc = tc_in & (state_reg == S_DMA);
  assign slot.dak_n = ~(((state_reg == S_DMA) ? 8'h01 : 8'h00) << chan_reg)
    & ~((s_drq1[isa_slot_pkg::CASCADE_CH] && state_reg == S_IDLE) ? 8'h10 : 8'h00);
  assign slot.h_addr = addr_reg;
  assign slot.h_addr_oe = s_mst[1] && state_reg != S_IDLE && state_reg != S_DMA;
  assign slot.h_data = hi_reg ? {8'h00, wdata_reg[15:8]} : wdata_reg;
  assign slot.h_data_oe = slot.h_addr_oe & write_reg;
  assign slot.h_ior_n = ~(state_reg == S_CMD & ~write_reg);
  assign slot.h_iow_n = ~(state_reg == S_CMD & write_reg);
  assign slot.h_cmd_oe = slot.h_addr_oe;
  assign slot.h_sbhe_n = ~(word_reg & ~split_reg);
  assign req_ready = state_reg == S_IDLE && edge_b && s_mst[1];
  assign done = done_reg;
  assign rdata = rdata_reg;
  assign dma_chan = chan_reg;
  assign dma_active = state_reg == S_DMA;
  assign dma_word = ~isa_slot_pkg::BYTE_CH_MASK[chan_reg];
  assign irq_num = irq_pick[3:0];
  assign irq_pending = irq_pick[4];
  assign chan_error = err_reg;
endmodule
`default_nettype wire

// ===== dv/isa_slot_checker.sv
// Purpose: timing checks on the slot wires
// Assumes: HALF equals the host divider
// Notes: host-side enables and resolved address watched
`timescale 1ns/1ps
`default_nettype none
module isa_slot_checker #(
  parameter int HALF = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bclk,
  input wire logic aen,
  input wire logic bale,
  input wire logic [7:0] dak_n,
  input wire logic [7:0] drq,
  input wire logic master_n,
  input wire logic chrdy_n_o,
  input wire logic h_addr_oe,
  input wire logic h_data_oe,
  input wire logic h_cmd_oe,
  input wire logic h_ior_n,
  input wire logic h_iow_n,
  input wire logic [23:0] addr
);
  logic [7:0] hcnt_reg;
  logic [7:0] slen_reg;
  logic [15:0] rlen_reg;
  logic [15:0] mlen_reg;
  logic bclk_d_reg;
  logic seen_reg;
  logic act;
  // host strobe active on the wire
  assign act = h_cmd_oe & ~(h_ior_n & h_iow_n);
  // half-period and strobe length counters
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hcnt_reg <= 8'h00;
      bclk_d_reg <= 1'b0;
      seen_reg <= 1'b0;
      slen_reg <= 8'h00;
      rlen_reg <= 16'h0000;
      mlen_reg <= 16'h0000;
    end
    else
    begin
      bclk_d_reg <= bclk;
      hcnt_reg <= (bclk != bclk_d_reg) ? 8'h00 : hcnt_reg + 8'h01;
      seen_reg <= seen_reg | (bclk != bclk_d_reg);
      slen_reg <= act ? slen_reg + 8'h01 : 8'h00;
      rlen_reg <= chrdy_n_o ? rlen_reg + 16'(~&rlen_reg) : 16'h0000; // saturating
      mlen_reg <= !master_n ? mlen_reg + 16'(~&mlen_reg) : 16'h0000;
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  sequence s_mst;
    !master_n [*4];
  endsequence
  sequence s_new_ack;
    (~dak_n & $past(dak_n)) != 8'h00;
  endsequence
  property p_bclk_duty;
    seen_reg && (bclk != bclk_d_reg) |-> hcnt_reg == HALF - 1;
  endproperty
  property p_strobe_whole;
    slen_reg != 8'h00 && !act |-> (slen_reg % (2 * HALF)) == 0 && slen_reg >= 4 * HALF;
  endproperty
  property p_dma_aen;
    (dak_n | 8'h10) != 8'hff |-> aen;
  endproperty
  property p_aen_bale;
    aen |-> bale;
  endproperty
  property p_dak_one;
    $onehot0(~dak_n);
  endproperty
  property p_dak_cause;
    s_new_ack |-> ((~dak_n & $past(dak_n)) & ~$past(drq)) == 8'h00;
  endproperty
  property p_dak_prio;
    s_new_ack |-> ($past(drq) & ((~dak_n & $past(dak_n)) - 8'h01)) == 8'h00;
  endproperty
  property p_master_off;
    s_mst |-> !h_addr_oe && !h_data_oe && !h_cmd_oe;
  endproperty
  property p_addr_valid;
    bale && !aen && master_n |-> h_addr_oe;
  endproperty
  property p_ready_max;
    rlen_reg < 16'(isa_slot_pkg::READY_MAX_CYC);
  endproperty
  property p_master_max;
    mlen_reg < 16'(isa_slot_pkg::MASTER_MAX_CYC);
  endproperty
  property p_latch_hold;
    $fell(bale) && !aen && master_n |-> $stable(addr);
  endproperty
  a_bclk_duty: assert property (p_bclk_duty) else $error("bus clock half period wrong");
  a_strobe_whole: assert property (p_strobe_whole) else $error("strobe not whole bus clocks");
  a_dma_aen: assert property (p_dma_aen) else $error("dma without address enable");
  a_aen_bale: assert property (p_aen_bale) else $error("latch enable low in dma");
  a_dak_one: assert property (p_dak_one) else $error("two acknowledges");
  a_dak_cause: assert property (p_dak_cause) else $error("acknowledge without request");
  a_dak_prio: assert property (p_dak_prio) else $error("lower channel acknowledged first");
  a_master_off: assert property (p_master_off) else $error("host drives under master");
  a_addr_valid: assert property (p_addr_valid) else $error("address not driven with latch");
  a_latch_hold: assert property (p_latch_hold) else $error("address moved at latch fall");
  a_ready_max: assert property (p_ready_max) else $error("ready held low too long");
  a_master_max: assert property (p_master_max) else $error("master select held too long");
endmodule
`default_nettype wire

// ===== dv/test_isa_host_slot_interface.sv
// Purpose: host and card ends joined and exercised
// Assumes: divider 2, card register at 0x300
// Notes: each test judges its own results
`timescale 1ns/1ps
`default_nettype none
module test_isa_host_slot_interface;
  localparam int HALF = 2;
  logic clk, rst_b, sys_reset, req_valid, req_write, req_word, irq_ack;
  logic [23:0] req_addr;
  logic [15:0] req_wdata, rdata, reg_value, irq_in;
  logic req_ready, done, dma_active, dma_word, irq_pending, chan_error, master_active;
  logic wide, err, take_bus, dma_granted, owns_bus;
  logic [7:0] dma_req;
  logic [2:0] dma_chan;
  logic [3:0] irq_num;
  int err_count, num_checks, cyc, s_cnt, s_len, n_strb, l8;
  isa_slot_if isa_slot_if_i ();
  isa_slot_host #(.HALF_DIV(HALF)) isa_slot_host_i (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .slot(isa_slot_if_i), .sys_reset(sys_reset), .req_valid(req_valid), .req_write(req_write),
    .req_word(req_word), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .done(done), .rdata(rdata), .tc_in(1'b0), .dma_chan(dma_chan), .dma_active(dma_active),
    .dma_word(dma_word), .irq_num(irq_num), .irq_pending(irq_pending), .irq_ack(irq_ack),
    .chan_error(chan_error), .master_active(master_active));
  isa_slot_card isa_slot_card_i (.clk(clk), .rst_b(rst_b), .ce(1'b1), .slot(isa_slot_if_i),
    .wide(wide), .dma_req(dma_req), .irq_in(irq_in), .err(err), .take_bus(take_bus),
    .reg_value(reg_value), .dma_granted(dma_granted), .owns_bus(owns_bus));
  isa_slot_checker #(.HALF(HALF)) isa_slot_checker_i (.clk(clk), .rst_b(rst_b),
    .bclk(isa_slot_if_i.bclk), .aen(isa_slot_if_i.aen), .bale(isa_slot_if_i.bale),
    .dak_n(isa_slot_if_i.dak_n), .drq(isa_slot_if_i.drq), .master_n(isa_slot_if_i.master_n),
    .h_addr_oe(isa_slot_if_i.h_addr_oe), .h_data_oe(isa_slot_if_i.h_data_oe),
    .h_cmd_oe(isa_slot_if_i.h_cmd_oe), .h_ior_n(isa_slot_if_i.h_ior_n),
    .h_iow_n(isa_slot_if_i.h_iow_n), .addr(isa_slot_if_i.addr), .chrdy_n_o(isa_slot_if_i.chrdy_n_o));
  // clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // strobe length and count, hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (!(isa_slot_if_i.ior_n & isa_slot_if_i.iow_n))
      s_cnt <= s_cnt + 1;
    else if (s_cnt != 0)
    begin
      s_len <= s_cnt;
      n_strb <= n_strb + 1;
      s_cnt <= 0;
    end
    if (cyc == 8000)
    begin
      err_count++;
      end_sim;
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one request at 0x300, held until taken, then wait for done
  task automatic bus(input logic wr, input logic [15:0] d);
    n_strb = 0;
    req_write = wr;
    req_wdata = d;
    req_valid = 1'b1;
    for (int i = 0; i < 400 && req_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (int i = 0; i < 400 && done !== 1'b1; i++) @(negedge clk);
    chk("done", 1, done);
  endtask
  task automatic t_io;
    wide = 1'b0;
    bus(1'b1, 16'ha55a);
    chk("strobes", 2, n_strb);
    chk("reg", 16'ha55a, reg_value);
    l8 = s_len;
    bus(1'b0, 16'h0000);
    chk("rdata", 16'ha55a, rdata);
    wide = 1'b1;
    bus(1'b1, 16'h1234);
    chk("wide strobes", 1, n_strb);
    // wide cycle is stretched one bus clock by the card's ready
    chk("wait", 2 * HALF * (isa_slot_pkg::BASE_WAITS - isa_slot_pkg::WIDE_WAITS - 1), l8 - s_len);
    bus(1'b0, 16'h0000);
    chk("wide rdata", 16'h1234, rdata);
    $display("test io end");
  endtask
  task automatic t_dma;
    dma_req = 8'h44;
    @(negedge clk);
    dma_req = 8'h00;
    for (int i = 0; i < 200 && dma_active !== 1'b1; i++) @(negedge clk);
    chk("chan", 2, dma_chan);
    chk("word", 0, dma_word);
    chk("dak", 8'hfb, isa_slot_if_i.dak_n);
    chk("granted", 1, dma_granted);
    chk("aen", 1, isa_slot_if_i.aen);
    for (int i = 0; i < 200 && dma_active !== 1'b0; i++) @(negedge clk);
    for (int i = 0; i < 200 && dma_active !== 1'b1; i++) @(negedge clk);
    chk("chan", 6, dma_chan);
    chk("word", 1, dma_word);
    chk("dak", 8'hbf, isa_slot_if_i.dak_n);
    for (int i = 0; i < 200 && dma_active !== 1'b0; i++) @(negedge clk);
    $display("test dma end");
  endtask
  task automatic ack;
    irq_ack = 1'b1;
    @(negedge clk);
    irq_ack = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_irq;
    irq_in = 16'h8208;
    for (int i = 0; i < 200 && irq_pending !== 1'b1; i++) @(negedge clk);
    chk("irq", 9, irq_num);
    ack;
    chk("irq", 15, irq_num);
    ack;
    chk("irq", 3, irq_num);
    ack;
    repeat (8) @(negedge clk);
    chk("pending", 0, irq_pending);
    irq_in = 16'h0000;
    $display("test irq end");
  endtask
  task automatic t_err;
    err = 1'b1;
    for (int i = 0; i < 200 && chan_error !== 1'b1; i++) @(negedge clk);
    err = 1'b0;
    repeat (10) @(negedge clk);
    chk("error", 1, chan_error);
    $display("test err end");
  endtask
  task automatic t_mst;
    take_bus = 1'b1;
    for (int i = 0; i < 300 && owns_bus !== 1'b1; i++) @(negedge clk);
    // host sees the select through its two-flop synchroniser
    repeat (2) @(negedge clk);
    chk("master", 1, master_active);
    chk("addr oe", 0, isa_slot_if_i.h_addr_oe);
    req_valid = 1'b1;
    l8 = 0;
    repeat (40)
    begin
      @(negedge clk);
      l8 = l8 | (req_ready !== 1'b0);
    end
    chk("ready", 0, l8);
    req_valid = 1'b0;
    take_bus = 1'b0;
    for (int i = 0; i < 300 && master_active !== 1'b0; i++) @(negedge clk);
    chk("released", 0, master_active);
    $display("test master end");
  endtask
  // reset, then the tests in turn
  initial
  begin
    {rst_b, sys_reset, req_valid, req_write, req_word, irq_ack, wide, err, take_bus} = 9'h000;
    {err_count, num_checks, cyc, s_cnt, s_len, n_strb, l8} = '0;
    req_addr = 24'h00_0300;
    req_word = 1'b1;
    req_wdata = 16'h0000;
    irq_in = 16'h0000;
    dma_req = 8'h00;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (8) @(negedge clk);
    t_io;
    t_dma;
    t_irq;
    t_err;
    t_mst;
    end_sim;
  end
endmodule
`default_nettype wire
